// >>> hw/pifr_pkg.sv
// Package for the peripheral interrupt flag register block.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz core clock.
package pifr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PIFR_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] PIFR_MASK_ADDR = 8'h10;
    localparam logic [7:0] PIFR_CTRL_ADDR = 8'h14;
    localparam logic [7:0] PIFR_FLAGS_RST = 8'h00;
    // Field positions
    localparam int PIFR_B_PAR = 7;
    localparam int PIFR_B_RSV = 6;
    localparam int PIFR_B_RX = 5;
    localparam int PIFR_B_TX = 4;
    localparam int PIFR_B_SSP = 3;
    localparam int PIFR_B_CCP = 2;
    localparam int PIFR_B_TM2 = 1;
    localparam int PIFR_B_TM1 = 0;
    // Implemented and software-writable flag bits
    localparam logic [7:0] PIFR_IMPL_MASK = 8'hBF;
    localparam logic [7:0] PIFR_SW_MASK = 8'h8F;
    // Capture/compare mode field in control register
    localparam int PIFR_CTRL_MODE_LSB = 0;
    localparam logic [1:0] PIFR_MODE_OFF = 2'h0;
    localparam logic [1:0] PIFR_MODE_CAPTURE = 2'h1;
    localparam logic [1:0] PIFR_MODE_COMPARE = 2'h2;
    localparam logic [1:0] PIFR_MODE_PWM = 2'h3;
    localparam logic [1:0] PIFR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIFR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {PIFR_WR_IDLE, PIFR_WR_RESP} pifr_wr_state_t;
endpackage

// >>> hw/pifr_evt_if.sv
// Interface carrying qualified event pulses from the event stage to the core.
// Assumes both modules share the core clock.
`timescale 1ns/1ps
interface pifr_evt_if;
    logic [7:0] set_pulse;
    logic rx_full;
    logic tx_empty;
    modport src (output set_pulse, output rx_full, output tx_empty);
    modport dst (input set_pulse, input rx_full, input tx_empty);
endinterface

// >>> hw/pifr_evt.sv
// Event stage: synchronises peripheral event lines and qualifies them.
// Assumes event lines may come from other domains; pulses are edge detected.
`timescale 1ns/1ps
module pifr_evt (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [1:0] i_ccp_mode,
    input wire logic [7:0] i_evt_raw,
    input wire logic i_rx_full_raw,
    input wire logic i_tx_empty_raw,
    pifr_evt_if.src evt
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [1:0] lv1_q;
    logic [1:0] lv2_q;
    logic [7:0] edge_w;
    logic ccp_en;

    // ------------------------------------------------------------
    // Two-stage synchronisers, then an edge register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
            lv1_q <= 2'h0;
            lv2_q <= 2'h0;
        end else if (i_ce) begin
            s1_q <= i_evt_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lv1_q <= {i_rx_full_raw, i_tx_empty_raw};
            lv2_q <= lv1_q;
        end
    end

    // Capture and compare feed the flag; pwm and off do not
    assign ccp_en = (i_ccp_mode == pifr_pkg::PIFR_MODE_CAPTURE) ||
                    (i_ccp_mode == pifr_pkg::PIFR_MODE_COMPARE);
    assign edge_w = s2_q & ~s3_q;

    // Rising edges become one-cycle set pulses; reserved bit never set
    always_comb begin
        evt.set_pulse = edge_w & pifr_pkg::PIFR_SW_MASK;
        evt.set_pulse[pifr_pkg::PIFR_B_CCP] = edge_w[pifr_pkg::PIFR_B_CCP] & ccp_en;
    end
    assign evt.rx_full = lv2_q[1];
    assign evt.tx_empty = lv2_q[0];
endmodule

// >>> hw/pifr_top.sv
// Peripheral interrupt flag register with AXI4-Lite slave and interrupt.
// Assumes the peripheral units drive event pulses/levels; one core clock.
//
// Notes on behaviour
// - Flag register is 8 bits at 0Ch
// - Bit 7 sets on completed parallel access
// - Unimplemented bits read zero, ignore writes
// - Bit 3 sets on serial transfer done
// - Capture mode: bit 2 sets on capture
// - Compare mode sets bit 2; pwm unused
// - Reset clears every implemented flag bit
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module pifr_top (
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    input wire logic I_PAR_DONE,
    input wire logic I_SSP_DONE,
    input wire logic I_CCP_EVENT,
    input wire logic I_TMR2_MATCH,
    input wire logic I_TIMER1_COUNT_OVF,
    input wire logic I_RX_FULL,
    input wire logic I_TX_EMPTY,
    input wire logic [31:0] I_AWADDR,
    input wire logic [2:0] I_AWPROT,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [31:0] I_ARADDR,
    input wire logic [2:0] I_ARPROT,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic O_IRQ
);
    pifr_evt_if evt_bus ();

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] mask_q;
    logic [1:0] mode_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [7:0] w_data_q;
    logic w_strb0_q;
    logic w_have_q;
    pifr_pkg::pifr_wr_state_t wr_st_q;
    logic wr_fire;
    logic [7:0] clr_w;
    logic [7:0] view_w;
    logic [7:0] raw_w;

    // Event lines in field order; bits 6,5,4 unused as pulses
    assign raw_w = {I_PAR_DONE, 1'b0, 1'b0, 1'b0, I_SSP_DONE, I_CCP_EVENT, I_TMR2_MATCH, I_TIMER1_COUNT_OVF};

    // ------------------------------------------------------------
    // Event stage
    // ------------------------------------------------------------
    pifr_evt u_evt (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_ccp_mode(mode_q),
        .i_evt_raw(raw_w),
        .i_rx_full_raw(I_RX_FULL),
        .i_tx_empty_raw(I_TX_EMPTY),
        .evt(evt_bus.src)
    );

    // Decodes a byte address into a register select
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
        addr_is = (a == reg_addr);
    endfunction

    // ------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------
    assign wr_fire = aw_have_q && w_have_q && (wr_st_q == pifr_pkg::PIFR_WR_IDLE);

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            O_AWREADY <= 1'b0;
        end else if (I_CE) begin
            O_AWREADY <= 1'b0;
            if (I_AWVALID && O_AWREADY) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= I_AWADDR[7:0];
            end else if (!aw_have_q && !O_AWREADY && I_AWVALID) begin
                O_AWREADY <= 1'b1;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    // Write data capture
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_strb0_q <= 1'b0;
            O_WREADY <= 1'b0;
        end else if (I_CE) begin
            O_WREADY <= 1'b0;
            if (I_WVALID && O_WREADY) begin
                w_have_q <= 1'b1;
                w_data_q <= I_WDATA[7:0];
                w_strb0_q <= I_WSTRB[0];
            end else if (!w_have_q && !O_WREADY && I_WVALID) begin
                O_WREADY <= 1'b1;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wr_st_q <= pifr_pkg::PIFR_WR_IDLE;
            O_BVALID <= 1'b0;
            O_BRESP <= pifr_pkg::PIFR_RESP_OKAY;
        end else if (I_CE) begin
            case (wr_st_q)
                pifr_pkg::PIFR_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_st_q <= pifr_pkg::PIFR_WR_RESP;
                        O_BVALID <= 1'b1;
                        if (addr_is(aw_addr_q, pifr_pkg::PIFR_FLAGS_ADDR) ||
                            addr_is(aw_addr_q, pifr_pkg::PIFR_MASK_ADDR) ||
                            addr_is(aw_addr_q, pifr_pkg::PIFR_CTRL_ADDR)) begin
                            O_BRESP <= pifr_pkg::PIFR_RESP_OKAY;
                        end else begin
                            O_BRESP <= pifr_pkg::PIFR_RESP_SLVERR;
                        end
                    end
                end
                pifr_pkg::PIFR_WR_RESP: begin
                    if (I_BREADY) begin
                        wr_st_q <= pifr_pkg::PIFR_WR_IDLE;
                        O_BVALID <= 1'b0;
                    end
                end
                default: begin
                    wr_st_q <= pifr_pkg::PIFR_WR_IDLE;
                    O_BVALID <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------
    // Write-one-to-clear on software-writable bits only
    assign clr_w = (wr_fire && w_strb0_q && addr_is(aw_addr_q, pifr_pkg::PIFR_FLAGS_ADDR)) ?
                   (w_data_q & pifr_pkg::PIFR_SW_MASK) : 8'h00;

    // Set wins over clear; sticky bits hold until cleared
    always_comb begin
        flags_d = ((flags_q & ~clr_w) | evt_bus.set_pulse) & pifr_pkg::PIFR_SW_MASK;
        flags_d[pifr_pkg::PIFR_B_RX] = evt_bus.rx_full;
        flags_d[pifr_pkg::PIFR_B_TX] = evt_bus.tx_empty;
        flags_d[pifr_pkg::PIFR_B_RSV] = 1'b0;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            flags_q <= pifr_pkg::PIFR_FLAGS_RST;
        end else if (I_CE) begin
            flags_q <= flags_d;
        end
    end

    // Mask and mode registers
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mask_q <= 8'h00;
            mode_q <= pifr_pkg::PIFR_MODE_OFF;
        end else if (I_CE && wr_fire && w_strb0_q) begin
            if (addr_is(aw_addr_q, pifr_pkg::PIFR_MASK_ADDR)) begin
                mask_q <= w_data_q & pifr_pkg::PIFR_IMPL_MASK;
            end
            if (addr_is(aw_addr_q, pifr_pkg::PIFR_CTRL_ADDR)) begin
                mode_q <= w_data_q[pifr_pkg::PIFR_CTRL_MODE_LSB +: 2];
            end
        end
    end

    // Interrupt level from unmasked flags
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_IRQ <= |(flags_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_comb begin
        if (addr_is(I_ARADDR[7:0], pifr_pkg::PIFR_FLAGS_ADDR)) begin
            view_w = flags_q & pifr_pkg::PIFR_IMPL_MASK;
        end else if (addr_is(I_ARADDR[7:0], pifr_pkg::PIFR_MASK_ADDR)) begin
            view_w = mask_q;
        end else begin
            view_w = {6'h00, mode_q};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= pifr_pkg::PIFR_RESP_OKAY;
        end else if (I_CE) begin
            O_ARREADY <= 1'b0;
            if (O_RVALID) begin
                if (I_RREADY) begin
                    O_RVALID <= 1'b0;
                end
            end else if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                if (addr_is(I_ARADDR[7:0], pifr_pkg::PIFR_FLAGS_ADDR) ||
                    addr_is(I_ARADDR[7:0], pifr_pkg::PIFR_MASK_ADDR) ||
                    addr_is(I_ARADDR[7:0], pifr_pkg::PIFR_CTRL_ADDR)) begin
                    O_RDATA <= {24'h000000, view_w};
                    O_RRESP <= pifr_pkg::PIFR_RESP_OKAY;
                end else begin
                    O_RDATA <= 32'h00000000;
                    O_RRESP <= pifr_pkg::PIFR_RESP_SLVERR;
                end
            end else if (I_ARVALID) begin
                O_ARREADY <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RSV_ZERO: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        flags_q[pifr_pkg::PIFR_B_RSV] == 1'b0) else $error("reserved flag bit set");
    AST_PAR_STICKY: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && evt_bus.set_pulse[pifr_pkg::PIFR_B_PAR]) |=> flags_q[pifr_pkg::PIFR_B_PAR])
        else $error("parallel flag not set");
    AST_SSP_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (flags_q[pifr_pkg::PIFR_B_SSP] && !clr_w[pifr_pkg::PIFR_B_SSP] && I_CE)
        |=> flags_q[pifr_pkg::PIFR_B_SSP]) else $error("serial flag lost");
    AST_CCP_PWM: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (mode_q == pifr_pkg::PIFR_MODE_PWM) |-> !evt_bus.set_pulse[pifr_pkg::PIFR_B_CCP])
        else $error("capcmp set in pwm mode");
    AST_CCP_CAP: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && evt_bus.set_pulse[pifr_pkg::PIFR_B_CCP]) |=> flags_q[pifr_pkg::PIFR_B_CCP])
        else $error("capcmp flag not set");
    AST_RX_FOLLOW: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        I_CE |=> flags_q[pifr_pkg::PIFR_B_RX] == $past(evt_bus.rx_full))
        else $error("rx flag not following buffer");
    AST_TM_STICKY: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (flags_q[1:0] != 2'h0 && clr_w[1:0] == 2'h0 && I_CE) |=> (flags_q[1:0] & $past(flags_q[1:0])) ==
        $past(flags_q[1:0])) else $error("timer flag dropped");
    AST_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        I_CE |=> O_IRQ == |($past(flags_d) & $past(mask_q))) else $error("irq level wrong");
    AST_TX_FOLLOW: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        I_CE |=> flags_q[pifr_pkg::PIFR_B_TX] == $past(evt_bus.tx_empty))
        else $error("tx flag not following buffer");
    AST_SSP_CLEAR: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && clr_w[pifr_pkg::PIFR_B_SSP] && !evt_bus.set_pulse[pifr_pkg::PIFR_B_SSP])
        |=> !flags_q[pifr_pkg::PIFR_B_SSP]) else $error("serial flag not cleared by write");
    AST_TM1_CLEAR: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && clr_w[pifr_pkg::PIFR_B_TM1] && !evt_bus.set_pulse[pifr_pkg::PIFR_B_TM1])
        |=> !flags_q[pifr_pkg::PIFR_B_TM1]) else $error("timer1 flag not cleared by write");
    AST_PAR_QUIET: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (!flags_q[pifr_pkg::PIFR_B_PAR] && !(I_CE && evt_bus.set_pulse[pifr_pkg::PIFR_B_PAR]))
        |=> !flags_q[pifr_pkg::PIFR_B_PAR]) else $error("parallel flag set without access");
    AST_CCP_OFF: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (mode_q == pifr_pkg::PIFR_MODE_OFF) |-> !evt_bus.set_pulse[pifr_pkg::PIFR_B_CCP])
        else $error("capcmp set with unit off");
    AST_RDATA_ZERO: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        O_RVALID |-> (O_RDATA[31:8] == 24'h000000) && !O_RDATA[pifr_pkg::PIFR_B_RSV])
        else $error("unimplemented read bits not zero");
    AST_CE_FREEZE: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        !I_CE |=> $stable(flags_q) && $stable(mask_q) && $stable(O_IRQ))
        else $error("state moved while clock enable low");
    AST_AWREADY_PULSE: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && O_AWREADY) |=> !O_AWREADY)
        else $error("write address ready held too long");
    AST_WREADY_PULSE: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && O_WREADY) |=> !O_WREADY)
        else $error("write data ready held too long");
    AST_ARREADY_PULSE: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        (I_CE && O_ARREADY) |=> !O_ARREADY)
        else $error("read address ready held too long");
endmodule

// >>> bench/pifr_top_tb_top.sv
// Self-checking testbench for the peripheral interrupt flag register block.
// Assumes the design answers every AXI4-Lite request within a few cycles.
`timescale 1ns/1ps
module pifr_top_tb_top;
    // ------------------------------------------------------------
    // Signals and shortcuts
    // ------------------------------------------------------------
    localparam logic [7:0] FA = pifr_pkg::PIFR_FLAGS_ADDR;
    localparam logic [7:0] MA = pifr_pkg::PIFR_MASK_ADDR;
    localparam logic [7:0] CA = pifr_pkg::PIFR_CTRL_ADDR;
    logic clk, arst_n, rx_full, tx_empty, ce;
    logic [4:0] ev;
    logic [31:0] awaddr, wdata, araddr, rdata, seed, d;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [7:0] e;
    int n_errors, checked;

    // Device under test, event vector order is par, ssp, capcmp, tmr2, timer1_count
    pifr_top dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_PAR_DONE(ev[4]), .I_SSP_DONE(ev[3]),
        .I_CCP_EVENT(ev[2]), .I_TMR2_MATCH(ev[1]), .I_TIMER1_COUNT_OVF(ev[0]), .I_RX_FULL(rx_full),
        .I_TX_EMPTY(tx_empty), .I_AWADDR(awaddr), .I_AWPROT(3'h0), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARPROT(3'h0), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_IRQ(irq));

    // Clock of 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Flags that an event vector sets; capcmp only counts in capture or compare
    function automatic logic [7:0] ev2flag(input logic [4:0] v, input logic [1:0] m);
        logic c;
        c = v[2] && (m == pifr_pkg::PIFR_MODE_CAPTURE || m == pifr_pkg::PIFR_MODE_COMPARE);
        return {v[4], 3'h0, v[3], c, v[1], v[0]};
    endfunction

    // ------------------------------------------------------------
    // Compare, report and bus tasks
    // ------------------------------------------------------------
    task automatic chk_data(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checked++;
        if (g !== ex) begin
            $display("ERROR %s expected %h seen %h", nm, ex, g);
            n_errors++;
        end
    endtask

    task automatic chk_bit(input string nm, input logic ex, input logic g);
        checked++;
        if (g !== ex) begin
            $display("ERROR %s expected %b seen %b", nm, ex, g);
            n_errors++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
        logic done, ta, tw, tb;
        done = 1'b0;
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            n_errors++;
            end_sim();
        end
    endtask

    // Read: address held until taken, ready held until data seen
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        logic done, ta, tr;
        done = 1'b0;
        @(posedge clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            dat = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            n_errors++;
            end_sim();
        end
    endtask

    // Event edge held three cycles, then time for sync and register
    task automatic pulse(input logic [4:0] v);
        @(posedge clk);
        ev <= v;
        repeat (3) @(posedge clk);
        ev <= 5'h00;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {arst_n, rx_full, tx_empty, ev, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        ce = 1'b1;
        seed = 32'hCF2351F4;
        n_errors = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(FA, d, r);
        chk_data("flags_rst", 32'h0, d);
        chk_data("rresp_ok", {30'h0, pifr_pkg::PIFR_RESP_OKAY}, {30'h0, r});
        @(negedge clk);
        chk_bit("irq_rst", 1'b0, irq);
        $display("test reset done");
        // Each source alone sets its sticky flag, except capcmp with mode off; write-one clears it
        for (int k = 0; k < 5; k++) begin
            pulse(5'h01 << k);
            e = ev2flag(5'h01 << k, pifr_pkg::PIFR_MODE_OFF);
            rd(FA, d, r);
            chk_data("flag_set", {24'h0, e}, d);
            wr(FA, {24'h0, e}, r);
            rd(FA, d, r);
            chk_data("flag_clr", 32'h0, d);
        end
        $display("test sources done");
        // Capture/compare flag in every mode
        for (int m = 0; m < 4; m++) begin
            wr(CA, m, r);
            pulse(5'h04);
            rd(FA, d, r);
            chk_data("capcmp", {24'h0, ev2flag(5'h04, m[1:0])}, d);
            wr(FA, 32'hBF, r);
        end
        $display("test capcmp modes done");
        // Buffer levels mirrored, read-only; reserved and upper bits stay zero
        rx_full <= 1'b1;
        tx_empty <= 1'b1;
        pulse(5'h00);
        rd(FA, d, r);
        chk_data("buf_levels", 32'h30, d);
        wr(FA, 32'hFFFFFFBF, r);
        rd(FA, d, r);
        chk_data("ro_bits", 32'h30, d);
        rx_full <= 1'b0;
        tx_empty <= 1'b0;
        pulse(5'h00);
        rd(FA, d, r);
        chk_data("buf_drop", 32'h0, d);
        $display("test buffer flags done");
        // Interrupt: masked, unmasked, cleared
        pulse(5'h01);
        chk_bit("irq_masked", 1'b0, irq);
        wr(MA, 32'hFF, r);
        rd(MA, d, r);
        chk_data("mask_rb", 32'hBF, d);
        @(negedge clk);
        chk_bit("irq_on", 1'b1, irq);
        wr(FA, 32'h01, r);
        pulse(5'h00);
        chk_bit("irq_off", 1'b0, irq);
        $display("test interrupt done");
        // Clock enable low freezes every flag, then a mid-run reset clears them
        pulse(5'h01);
        @(posedge clk);
        ce <= 1'b0;
        pulse(5'h10);
        @(posedge clk);
        ce <= 1'b1;
        pulse(5'h00);
        rd(FA, d, r);
        chk_data("ce_freeze", {24'h0, ev2flag(5'h01, pifr_pkg::PIFR_MODE_OFF)}, d);
        @(negedge clk);
        chk_bit("irq_held", 1'b1, irq);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk_bit("irq_rst2", 1'b0, irq);
        rd(FA, d, r);
        chk_data("flags_rst2", 32'h0, d);
        $display("test clock enable and reset done");
        // Unmapped addresses are refused
        rd(8'h20, d, r);
        chk_data("unm_rresp", {30'h0, pifr_pkg::PIFR_RESP_SLVERR}, {30'h0, r});
        chk_data("unm_rdata", 32'h0, d);
        wr(8'h24, 32'h8F, r);
        chk_data("unm_bresp", {30'h0, pifr_pkg::PIFR_RESP_SLVERR}, {30'h0, r});
        $display("test unmapped done");
        // Random events, modes and partial clears
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            wr(CA, {30'h0, seed[9:8]}, r);
            pulse(seed[4:0]);
            e = ev2flag(seed[4:0], seed[9:8]);
            rd(FA, d, r);
            chk_data("rnd_set", {24'h0, e}, d);
            wr(FA, {24'h0, seed[23:16] & 8'hBF}, r);
            rd(FA, d, r);
            chk_data("rnd_clr", {24'h0, e & ~(seed[23:16] & pifr_pkg::PIFR_SW_MASK)}, d);
            wr(FA, 32'hBF, r);
        end
        $display("test random done");
        end_sim();
    end
endmodule
